// ### core/smb_pkg.sv
// Shared constants and carrier types for the serial bus frame logic.
// Assumes a single 250 MHz clock domain in the core.
`default_nettype none
package smb_pkg;
    localparam int CLK_MHZ       = 250;
    // Sync threshold: longer than one bus period at the slowest rate (10 kHz = 100 us)
    // would break detection, so use a fraction of the 82 us minimum sync.
    localparam int SYNC_MIN_US   = 82;
    localparam int SYNC_THR_US   = 60;
    localparam int SYNC_CYC      = SYNC_THR_US * CLK_MHZ;
    localparam int ADDR_W        = 8;
    localparam int PULSE_W       = 9;
    localparam logic [ADDR_W-1:0] ADDR_NONE = 8'h00;
    localparam int FIFO_DEPTH    = 8;

    typedef enum logic [1:0] {
        SMB_PEER   = 2'h1,
        SMB_MASTER = 2'h2
    } smb_mode_t;

    // One received bit: address, phase and value
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              outPhase;
        logic              value;
    } smb_rx_t;

    localparam int RX_W = ADDR_W + 2;
endpackage : smb_pkg
`default_nettype wire

// ### core/smb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the core clock.
`default_nettype none
module smb_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0]   cnt;
    } smb_fifo_st_t;

    smb_fifo_st_t st_ff, nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) $error("DEPTH must be a power of two >= 2");
    end

    assign inReady  = (st_ff.cnt != DEPTH[PW:0]);
    assign outValid = (st_ff.cnt != '0);
    assign outData  = mem[st_ff.rp];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        nxt_st = st_ff;
        if (push) nxt_st.wp = st_ff.wp + 1'b1;
        if (pop) nxt_st.rp = st_ff.rp + 1'b1;
        nxt_st.cnt = st_ff.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
        if (push) mem[st_ff.wp] <= inData;
    end
endmodule : smb_fifo
`default_nettype wire

// ### core/smb_frame_io.sv
// Frame counter and per-address data line access for the two-wire control bus.
// Assumes bus clock and data pins are asynchronous; data pin is open drain.
`default_nettype none
module smb_frame_io #(
    parameter int SYNC_THR = smb_pkg::SYNC_CYC
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Configuration
    input  wire logic [1:0]                  modeSel,
    input  wire logic [255:0]                inAddrEn,
    input  wire logic [255:0]                outAddrEn,
    input  wire logic [255:0]                txBits,
    // Bus pins
    input  wire logic                        busClkIn,
    input  wire logic                        busDataIn,
    output logic                             busDataOut,
    output logic                             busDataOe,
    // Status and received bits
    output logic                             frameSync,
    output logic [smb_pkg::ADDR_W-1:0]       curAddr,
    output logic [255:0]                     rxBits,
    output logic                             cfgError,
    // Received bit stream
    output logic                             rxValid,
    input  wire logic                        rxReady,
    output logic [smb_pkg::RX_W-1:0]         rxData,
    output logic                             rxOverflow
);
    initial begin
        if (SYNC_THR < 2 || SYNC_THR > 32'h00ff_ffff) $error("SYNC_THR out of range");
    end

    // Address taken by a pulse count in the selected mode
    function automatic logic [smb_pkg::ADDR_W-1:0] pulseAddr(
        input logic [smb_pkg::PULSE_W-1:0] cnt,
        input logic                        master
    );
        pulseAddr = master ? cnt[smb_pkg::PULSE_W-1:1]
                           : cnt[smb_pkg::ADDR_W-1:0];
    endfunction : pulseAddr

    typedef struct packed {
        logic [2:0]                    clkSync;
        logic [2:0]                    datSync;
        logic                          clkLvl;
        logic                          datLvl;
        logic [23:0]                   idleCnt;
        logic                          inSync;
        logic                          started;
        logic [smb_pkg::PULSE_W-1:0]   pulseCnt;
        logic                          drive;
        logic                          active;
        logic                          sampleDue;
        logic                          syncPulse;
        logic [smb_pkg::ADDR_W-1:0]    addr;
        logic [255:0]                  rx;
        logic                          cfgErr;
        logic                          ovf;
    } smb_st_t;

    smb_st_t st_ff, nxt_st;
    logic            isMaster;
    logic            clkFall, clkRise;
    logic            outPh;
    logic [smb_pkg::ADDR_W-1:0] addrNow;
    logic            ownIn, ownOut, wantDrive, wantSample;
    smb_pkg::smb_rx_t rxWord;
    logic            fifoInReady;
    logic            push;
    logic            fifoOutValid;
    logic [smb_pkg::RX_W-1:0] fifoOutData;

    assign isMaster = (modeSel == smb_pkg::SMB_MASTER);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.syncPulse = 1'b0;
        nxt_st.sampleDue = 1'b0;
        nxt_st.clkSync = {st_ff.clkSync[1:0], busClkIn};
        nxt_st.datSync = {st_ff.datSync[1:0], busDataIn};
        if (st_ff.clkSync[2] == st_ff.clkSync[1]) nxt_st.clkLvl = st_ff.clkSync[1];
        if (st_ff.datSync[2] == st_ff.datSync[1]) nxt_st.datLvl = st_ff.datSync[1];
        clkFall = st_ff.clkLvl && !nxt_st.clkLvl;
        clkRise = !st_ff.clkLvl && nxt_st.clkLvl;

        // Idle high clock timer; threshold under one period at the slowest rate
        if (!nxt_st.clkLvl || clkRise) begin
            nxt_st.idleCnt = '0;
        end else if (st_ff.idleCnt != SYNC_THR[23:0]) begin
            nxt_st.idleCnt = st_ff.idleCnt + 24'h00_0001;
        end
        if (st_ff.idleCnt == SYNC_THR[23:0] - 24'h00_0001 && nxt_st.clkLvl) begin
            nxt_st.inSync    = 1'b1;
            nxt_st.syncPulse = 1'b1;
            nxt_st.pulseCnt  = '0;
            nxt_st.started   = 1'b0;
            nxt_st.drive     = 1'b0;
            nxt_st.active    = 1'b0;
            nxt_st.addr      = '0;
        end

        // Falling clock edge opens a period
        outPh      = isMaster && st_ff.pulseCnt[0];
        addrNow    = pulseAddr(st_ff.pulseCnt, isMaster);
        ownIn      = inAddrEn[addrNow] && (addrNow != smb_pkg::ADDR_NONE);
        ownOut     = outAddrEn[addrNow] && (addrNow != smb_pkg::ADDR_NONE);
        // Peer: one bit per period; master/slave: drive only input phase
        wantDrive  = ownIn && !outPh && txBits[addrNow];
        // Peer: outputs follow line; master/slave: only output phase heard
        wantSample = ownOut && (!isMaster || outPh);

        if (clkFall) begin
            nxt_st.inSync = 1'b0;
            if (st_ff.started) begin
                nxt_st.pulseCnt = st_ff.pulseCnt + 9'h001;
            end
            nxt_st.started = 1'b1;
        end
        if (clkFall) begin
            outPh   = isMaster && nxt_st.pulseCnt[0];
            addrNow = pulseAddr(nxt_st.pulseCnt, isMaster);
            ownIn   = inAddrEn[addrNow] && (addrNow != smb_pkg::ADDR_NONE);
            ownOut  = outAddrEn[addrNow] && (addrNow != smb_pkg::ADDR_NONE);
            wantDrive  = ownIn && !outPh && txBits[addrNow];
            wantSample = ownOut && (!isMaster || outPh);
            nxt_st.drive  = wantDrive;
            nxt_st.active = wantSample;
            nxt_st.addr   = addrNow;
        end
        // Late in the period: rising edge releases the line and flags the sample, which is stored a cycle later
        if (clkRise && st_ff.started) begin
            nxt_st.sampleDue = st_ff.active;
            nxt_st.drive     = 1'b0;
            nxt_st.active    = 1'b0;
        end
        if (st_ff.sampleDue) begin
            nxt_st.rx[st_ff.addr] = !st_ff.datLvl;
        end
        if (st_ff.sampleDue && !fifoInReady) nxt_st.ovf = 1'b1;
        // Master mode frames past 511 pulses wrap; peer past 255 likewise
        nxt_st.cfgErr = ((inAddrEn | outAddrEn) == '0)
                      || inAddrEn[0] || outAddrEn[0];
    end

    assign rxWord.addr     = st_ff.addr;
    assign rxWord.outPhase = isMaster;
    assign rxWord.value    = !st_ff.datLvl;
    assign push            = st_ff.sampleDue;

    // Open drain: the pin is only ever pulled low
    assign busDataOut = 1'b0;
    assign busDataOe  = st_ff.drive;
    assign frameSync  = st_ff.inSync;
    assign curAddr    = st_ff.addr;
    assign rxBits     = st_ff.rx;
    assign cfgError   = st_ff.cfgErr;
    assign rxOverflow = st_ff.ovf;
    assign rxValid    = fifoOutValid;
    assign rxData     = fifoOutData;

    smb_fifo #(
        .WIDTH (smb_pkg::RX_W),
        .DEPTH (smb_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inValid  (push),
        .inReady  (fifoInReady),
        .inData   (rxWord),
        .outValid (fifoOutValid),
        .outReady (rxReady),
        .outData  (fifoOutData)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff         <= '0;
            st_ff.clkSync <= 3'h7;
            st_ff.datSync <= 3'h7;
            st_ff.clkLvl  <= 1'b1;
            st_ff.datLvl  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : smb_frame_io
`default_nettype wire


// ### testbench/smb_far_end.sv
// Far-end model: bus clock source plus the other devices on the data line.
// Assumes 16-cycle bus periods; the bench resolves the wired line.
`default_nettype none
module smb_far_end (
    // Core clock and frame content
    input  wire logic        clk,
    input  wire logic        master,
    input  wire logic [31:0] fIn,
    input  wire logic [31:0] fOut,
    // Bus side
    output logic             busClk,
    output logic             pullLow,
    input  wire logic        busLine,
    // Line levels seen late in each period
    output logic [31:0]      seenIn,
    output logic [31:0]      seenOut
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        busClk = 1'b1;
        pullLow = 1'b0;
    end
    // Sync before and after, so every frame stands alone
    task automatic run_frame();
        logic [7:0] a;
        seenIn = '0;
        seenOut = '0;
        repeat (140) @(posedge clk);
        for (int p = 0; p < (master ? 64 : 32); p++) begin
            a = master ? 8'(p >> 1) : 8'(p);
            busClk <= 1'b0;
            repeat (4) @(posedge clk);
            // Held 4 cycles past the next fall to cover the sampler's lag
            pullLow <= (master && p[0]) ? fOut[a] : fIn[a];
            // Look before the rise: the device lets go of the line there
            repeat (3) @(posedge clk);
            if (master && p[0]) seenOut[a] = !busLine;
            else seenIn[a] = !busLine;
            @(posedge clk);
            busClk <= 1'b1;
            repeat (8) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        pullLow <= 1'b0;
        repeat (140) @(posedge clk);
    endtask : run_frame
endmodule : smb_far_end
`default_nettype wire

// ### testbench/smb_frame_io_chk.sv
// Port checker for the frame io block.
// Assumes 16-cycle bus periods from the far end.
`default_nettype none
module smb_frame_io_chk #(
    parameter int SYNC_THR = 20
) (
    // Clock and reset
    input wire logic         clk,
    input wire logic         rst_n,
    // Watched ports
    input wire logic         busClkIn,
    input wire logic         busDataOut,
    input wire logic         busDataOe,
    input wire logic         frameSync,
    input wire logic [7:0]   curAddr,
    input wire logic [255:0] inAddrEn,
    input wire logic [255:0] txBits,
    input wire logic         rxValid,
    input wire logic         rxReady,
    input wire logic [9:0]   rxData,
    input wire logic         rxOverflow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] idle;
    logic [5:0]  age;
    logic [7:0]  prev;
    logic        seen;
    logic        own;
    assign own = inAddrEn[curAddr] && txBits[curAddr] && curAddr != 8'h00;
    // Age skips the cycles where drive and address move together
    always_ff @(posedge clk) begin
        prev <= rst_n ? curAddr : 8'h00;
        age <= (!rst_n || curAddr != prev) ? 6'h00 : age + 6'(age != 6'h3f);
        idle <= (!rst_n || !busClkIn) ? 16'h0000 : idle + 16'(idle != 16'hffff);
        seen <= rst_n && busClkIn && (seen || frameSync);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_open_drain: assert property (busDataOe |-> !busDataOut)
        else $error("line driven high");
    chk_own_addr: assert property (busDataOe && age > 6'h02 |-> own)
        else $error("line pulled at foreign address");
    chk_sync_clear: assert property (idle == SYNC_THR + 8 |->
        curAddr == 8'h00 && !busDataOe) else $error("address kept in sync");
    chk_sync_seen: assert property (idle == SYNC_THR + 8 |-> seen)
        else $error("sync not flagged");
    chk_early_sync: assert property ($rose(frameSync) |-> idle > 16'h000c)
        else $error("sync flagged in frame");
    chk_addr_step: assert property ($changed(curAddr) |->
        curAddr == 8'h00 || curAddr == $past(curAddr) + 8'h01) else $error("address skipped");
    chk_addr_rate: assert property ($changed(curAddr) && curAddr > 8'h01 |->
        age == 6'h0f || age == 6'h1f) else $error("address rate wrong");
    chk_rx_hold: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
        else $error("stalled word changed");
    cov_drive: cover property (busDataOe ##1 !busDataOe);
    cov_stall: cover property (rxValid && !rxReady ##1 rxReady);
    cov_overflow: cover property (rxOverflow);
endmodule : smb_frame_io_chk
bind smb_frame_io smb_frame_io_chk #(.SYNC_THR(SYNC_THR)) i_chk (
    .clk(clk), .rst_n(rst_n), .busClkIn(busClkIn), .busDataOut(busDataOut),
    .busDataOe(busDataOe), .frameSync(frameSync), .curAddr(curAddr), .inAddrEn(inAddrEn),
    .txBits(txBits), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
    .rxOverflow(rxOverflow));
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench: reset, then frame rows and fifo stall cases.
// Assumes the far-end model as clock source and a pulled-up data line.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        master;
        logic [31:0] inEn, outEn, tx, fIn, fOut;
    } smb_row_t;
    logic clk, rst_n, rxReady, ovSeen, busClk, pullLow, busDataOut, busDataOe;
    logic frameSync, rxValid, rxOverflow;
    logic [7:0] curAddr;
    logic [255:0] rxBits;
    logic [9:0] rxData;
    logic [31:0] seenIn, seenOut;
    smb_row_t cur;
    int errTotal, nTests;
    smb_pkg::smb_rx_t q[$];
    wire busLine = !pullLow && !(busDataOe && !busDataOut);
    // Address 0 and 31 sit at the edges; rows 1 and 2 share in/out addresses
    smb_row_t rows [4] = '{
        '{1'b0, 32'h000000f1, 32'h00000f00, 32'h000000a1, 32'h00000500, 32'h0},
        '{1'b0, 32'h80030000, 32'h80030000, 32'h00010000, 32'h80000000, 32'h0},
        '{1'b1, 32'h0000f000, 32'h000ff000, 32'h00005000, 32'h000a0000, 32'h00033000},
        '{1'b1, 32'h80000001, 32'h40000000, 32'h80000001, 32'h0, 32'h40000000}};
    smb_frame_io #(.SYNC_THR(20)) i_dut (
        .clk(clk), .rst_n(rst_n),
        .modeSel(cur.master ? smb_pkg::SMB_MASTER : smb_pkg::SMB_PEER),
        .inAddrEn({224'h0, cur.inEn}), .outAddrEn({224'h0, cur.outEn}),
        .txBits({224'h0, cur.tx}), .busClkIn(busClk), .busDataIn(busLine),
        .busDataOut(busDataOut), .busDataOe(busDataOe), .frameSync(frameSync),
        .curAddr(curAddr), .rxBits(rxBits), .cfgError(), .rxValid(rxValid),
        .rxReady(rxReady), .rxData(rxData), .rxOverflow(rxOverflow));
    smb_far_end i_far (
        .clk(clk), .master(cur.master), .fIn(cur.fIn), .fOut(cur.fOut), .busClk(busClk),
        .pullLow(pullLow), .busLine(busLine), .seenIn(seenIn), .seenOut(seenOut));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rxOverflow === 1'b1) ovSeen <= 1'b1;
        if (rst_n && rxValid === 1'b1 && rxReady) q.push_back(smb_pkg::smb_rx_t'(rxData));
    end
    task automatic check(string what, logic [255:0] seen, logic [255:0] exp);
        nTests++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic run_row(smb_row_t r);
        logic [31:0] drv;
        logic [31:0] expRx;
        drv = r.inEn & r.tx & 32'hfffffffe;
        expRx = r.outEn & (r.master ? r.fOut : (r.fIn | drv));
        q.delete();
        cur <= r;
        i_far.run_frame();
        check("seenIn", seenIn, r.fIn | drv);
        check("seenOut", seenOut, r.master ? r.fOut : 32'h0);
        check("rxBits", rxBits & {224'h0, r.outEn}, expRx);
        check("rxCount", q.size(), $countones(r.outEn));
        foreach (q[k]) check("rxBit", q[k].value, expRx[q[k].addr]);
    endtask : run_row
    initial begin
        rst_n = 1'b0;
        rxReady = 1'b1;
        ovSeen = 1'b0;
        cur = '0;
        errTotal = 0;
        nTests = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check("resetOe", busDataOe, 1'b0);
        check("resetAddr", curAddr, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // Eleven words against a stalled drain side
        q.delete();
        rxReady <= 1'b0;
        cur <= '{1'b0, 32'h0, 32'h00000ffe, 32'h0, 32'h00000aaa, 32'h0};
        i_far.run_frame();
        check("overflow", ovSeen, 1'b1);
        rxReady <= 1'b1;
        for (int k = 0; k < 40 && rxValid !== 1'b0; k++) @(posedge clk);
        check("drained", rxValid, 1'b0);
        if (rxValid !== 1'b0) tally_and_finish();
        check("fifoCount", q.size(), smb_pkg::FIFO_DEPTH);
        check("fifoHead", q[0].addr, 8'h01);
        check("fifoTail", q[7].addr, 8'h08);
        $display("fifo test done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
